// File: rtl/mpc_pkg.sv
package mpc_pkg;
  // register byte offsets on the bus
  localparam logic [11:0] OFS_EVT = 12'h000;
  localparam logic [11:0] OFS_PHS = 12'h004;
  localparam logic [11:0] OFS_CFR = 12'h008;
  localparam logic [11:0] OFS_MODE = 12'h00c;
  // event control field positions
  localparam int EVT_FLAG = 7;
  localparam int EVT_HZ = 6;
  localparam int EVT_SZ = 5;
  localparam int EVT_SC = 4;
  localparam int EVT_FAST_ZERO_SAMPLING = 3;
  // current feedback field positions
  localparam int CFR_PAGE = 7;
  localparam int CFR_RST = 6;
  localparam int CFR_CFF = 3;
  localparam int CFR_CFW = 0;
  // mode register field positions
  localparam int MODE_TES = 0;
  localparam int MODE_SWA = 2;
  localparam int MODE_DAC = 3;
  localparam int MODE_PCN = 4;
  localparam int MODE_DTE = 5;
  localparam int MODE_CUR = 6;
  localparam int MODE_W = 7;
  // reset values and codes
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [MODE_W-1:0] MODE_RST = 7'h00;
  localparam logic [1:0] TES_POSITION = 2'h0;
  localparam logic [1:0] IS_ENCODER = 2'h3;
  localparam logic [2:0] VR_EXTERNAL = 3'h7;
  // timing: blank step at the nominal peripheral rate
  localparam int PERIPH_KHZ = 4000;
  localparam int BLANK_STEP_NS = 500;
  localparam int BLANK_STEP_CYC = (BLANK_STEP_NS * PERIPH_KHZ) / 1000000;
  localparam int SAMPLE_DIV = 4;
  // blanking window states
  typedef enum logic {MPC_IDLE, MPC_BLANK} mpc_blank_e;
  // speed-sensor modes share the event register bits 7:6
  function automatic logic mpc_is_speed(input logic [1:0] timer_sensor_mode);
    return timer_sensor_mode != TES_POSITION;
  endfunction : mpc_is_speed
endpackage : mpc_pkg

// File: rtl/mpc_cur_filter.sv
`timescale 1ns/10ps
module mpc_cur_filter
  import mpc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic soft_clr,
  // settings
  input wire logic [2:0] filter_count,
  input wire logic [2:0] blank_window,
  // comparator side
  input wire logic pwm_on,
  input wire logic over_limit,
  // results
  output logic current_event,
  output logic blanking
);
  localparam int DIV_W = $clog2(SAMPLE_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SAMPLE_DIV - 1);
  localparam logic [4:0] STEP = 5'(BLANK_STEP_CYC);

  mpc_blank_e state, next_state;
  logic [DIV_W-1:0] div, next_div;
  logic [4:0] bcnt, next_bcnt;
  logic [3:0] run, next_run;
  logic pwm_d, next_pwm_d;
  logic next_event;
  logic sample;
  logic [3:0] need;

  // quarter-rate sampling, blank window, consecutive count
  always_comb begin
    next_div = div + 1'b1;
    sample = (div == DIV_LAST); // R18
    next_pwm_d = pwm_on;
    next_state = state;
    next_bcnt = bcnt;
    next_run = run;
    next_event = 1'b0;
    need = {1'b0, filter_count} + 4'h1; // R18
    unique case (state)
      MPC_IDLE: begin
        if (pwm_on && !pwm_d && blank_window != 3'h0) begin
          next_state = MPC_BLANK; // R19
          next_bcnt = 5'(blank_window * STEP) - 5'h1; // R22
        end
      end
      MPC_BLANK: begin
        if (bcnt == 5'h0) begin
          next_state = MPC_IDLE;
        end else begin
          next_bcnt = bcnt - 5'h1;
        end
      end
    endcase
    // a blanked sample counts as below the limit
    if (sample) begin
      if (over_limit && state == MPC_IDLE) begin
        if (run < need) begin
          next_run = run + 4'h1;
          next_event = (run + 4'h1 == need); // R18
        end
      end else begin
        next_run = 4'h0;
      end
    end
    if (soft_clr) begin
      next_state = MPC_IDLE;
      next_run = 4'h0;
      next_event = 1'b0;
    end
  end

  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= MPC_IDLE;
      div <= '0;
      bcnt <= 5'h0;
      run <= 4'h0;
      pwm_d <= 1'b0;
      current_event <= 1'b0;
      blanking <= 1'b0;
    end else begin
      state <= next_state;
      div <= next_div;
      bcnt <= next_bcnt;
      run <= next_run;
      pwm_d <= next_pwm_d;
      current_event <= next_event;
      blanking <= (next_state == MPC_BLANK);
    end
  end
endmodule : mpc_cur_filter

// File: rtl/mpc_phase_regs.sv
// Overview of operation
// R1: position modes: timer overflow sets sticky top flag
// R2: speed modes: top flag is speed error pending
// R3: position modes: bit 6 selects hardware zero
// R4: speed modes: bit 6 reads quadrature lead
// R5: simulated-zero bit enables simulated zero events
// R6: auto-switched: simulated-commutation bit picks commutation source
// R7: zero sampled at off-time end or fast
// R8: fast sampling forces minimum off time zero
// R9: threshold field; all ones selects external pin
// R10: input select routes A, B, C or encoder
// R11: encoder mode passes A and B digitally
// R12: channel bits apply at commutation or immediately
// R13: channel bit off/on; meaningless with three-pwm/dead-time
// R14: whole phase register preloaded until commutation
// R15: phase register written as a whole byte
// R16: page bit chooses register page at shared addresses
// R17: soft reset bit clears all motor registers
// R18: filter needs code+1 samples at quarter rate
// R19: blanking window starts at each pwm turn-on
// R20: registers reset to zero; direction bit read-only
// R21: direct-access channel write makes commutation event
// R22: blank window counts two cycles per step
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/10ps
module mpc_phase_regs
  import mpc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // motor timer and position inputs
  input wire logic motor_timer_ovf,
  input wire logic speed_error,
  input wire logic position_input_a,
  input wire logic position_input_b,
  input wire logic position_input_c,
  // event sources
  input wire logic hw_zero_event,
  input wire logic sim_zero_req,
  input wire logic hw_comm_event,
  input wire logic sim_comm_req,
  input wire logic filter_sample_clock,
  input wire logic pwm_on,
  input wire logic current_over_limit,
  // events out
  output logic zero_event,
  output logic comm_event,
  output logic current_event,
  output logic current_blanking,
  // output stage and comparator control
  output logic [5:0] channel_on_off,
  output logic channel_bits_valid,
  output logic [1:0] input_select,
  output logic encoder_mode,
  output logic encoder_a,
  output logic encoder_b,
  output logic [2:0] threshold_select,
  output logic external_threshold_sel,
  output logic zero_sample_fast,
  output logic min_off_time_zero,
  output logic page_select
);
  // register state
  logic [7:0] evt, next_evt;
  logic [7:0] phs_pre, next_phs_pre;
  logic [7:0] phs_act, next_phs_act;
  logic [7:0] cfr, next_cfr;
  logic [MODE_W-1:0] mode, next_mode;
  logic dir, next_dir;
  logic a_d, pwm_d;
  logic next_zero, next_comm;
  // bus state
  logic [31:0] next_prdata, rd;
  logic next_pready, next_pslverr;
  // decode
  logic wr_acc, wr_evt, wr_phs, wr_cfr, wr_mode, soft_rst, speed, hit;
  logic comm_src, sample_ok, dac, setup;

  // write strobes; a partial write without byte lane 0 is dropped
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite && pstrb[0]; // R15
  assign wr_evt = wr_acc && !cfr[CFR_PAGE] && paddr == OFS_EVT; // R16
  assign wr_phs = wr_acc && !cfr[CFR_PAGE] && paddr == OFS_PHS; // R16
  assign wr_cfr = wr_acc && paddr == OFS_CFR;
  assign wr_mode = wr_acc && paddr == OFS_MODE;
  assign soft_rst = wr_cfr && pwdata[CFR_RST]; // R17
  assign speed = mpc_is_speed(mode[MODE_TES +: 2]);
  assign dac = mode[MODE_DAC];
  assign hit = paddr == OFS_EVT || paddr == OFS_PHS || paddr == OFS_CFR || paddr == OFS_MODE;

  // commutation source selection
  always_comb begin
    if (mode[MODE_SWA] && evt[EVT_SC]) begin
      comm_src = sim_comm_req; // R6
    end else begin
      comm_src = hw_comm_event; // R6
    end
  end

  // zero-crossing sample point: end of off time or fast clock
  assign sample_ok = evt[EVT_FAST_ZERO_SAMPLING] ? filter_sample_clock : (pwm_on && !pwm_d); // R7

  // event control register
  always_comb begin
    next_evt = evt;
    if (wr_evt) begin
      next_evt[5:0] = pwdata[5:0];
      if (!speed) begin
        next_evt[EVT_HZ] = pwdata[EVT_HZ]; // R3
      end
      // software clears the flag by writing zero
      if (!pwdata[EVT_FLAG]) begin
        next_evt[EVT_FLAG] = 1'b0;
      end
    end
    // set wins over a clear in the same cycle
    if (speed ? speed_error : motor_timer_ovf) begin
      next_evt[EVT_FLAG] = 1'b1; // R1 R2
    end
    if (soft_rst) begin
      next_evt = REG_RST; // R17
    end
  end

  // phase state: preload and active copies
  always_comb begin
    next_phs_pre = phs_pre;
    next_phs_act = phs_act;
    next_comm = comm_src;
    if (wr_phs) begin
      next_phs_pre = pwdata[7:0]; // R14 R15
    end
    if (dac && wr_phs) begin
      next_phs_act = pwdata[7:0]; // R12
      next_comm = 1'b1; // R21
    end else if (comm_src) begin
      next_phs_act = phs_pre; // R14
    end
    if (soft_rst) begin
      next_phs_pre = REG_RST; // R17
      next_phs_act = REG_RST;
      next_comm = 1'b0;
    end
  end

  // current feedback and mode registers
  always_comb begin
    next_cfr = cfr;
    next_mode = mode;
    if (wr_cfr) begin
      next_cfr = pwdata[7:0];
      next_cfr[CFR_RST] = 1'b0; // reset bit reads back zero
    end
    if (wr_mode) begin
      next_mode = pwdata[MODE_W-1:0];
    end
    if (soft_rst) begin
      next_cfr = REG_RST; // R17
      next_mode = MODE_RST;
    end
  end

  // zero event and encoder direction
  always_comb begin
    next_zero = 1'b0;
    // hardware zero only counts in the position/sensorless modes
    if (!speed && evt[EVT_HZ] && hw_zero_event && sample_ok) begin
      next_zero = 1'b1; // R3 R7
    end
    if (evt[EVT_SZ] && sim_zero_req) begin
      next_zero = 1'b1; // R5
    end
    // on a rise of A, a low B means A leads
    next_dir = dir;
    if (position_input_a && !a_d) begin
      next_dir = !position_input_b; // R4
    end
    if (soft_rst) begin
      next_zero = 1'b0;
    end
  end

  // read mux; page 1 shows live state at the shared offsets
  always_comb begin
    rd = 32'h0000_0000;
    unique case (1'b1)
      paddr == OFS_EVT: begin
        if (cfr[CFR_PAGE]) begin
          rd[7:0] = phs_act; // R16
        end else begin
          rd[7:0] = evt;
          rd[EVT_HZ] = speed ? dir : evt[EVT_HZ]; // R4 R20
        end
      end
      paddr == OFS_PHS: begin
        if (cfr[CFR_PAGE]) begin
          rd[1:0] = {current_blanking, current_event}; // R16
        end else begin
          rd[7:0] = phs_pre;
        end
      end
      paddr == OFS_CFR: rd[7:0] = cfr;
      paddr == OFS_MODE: rd[MODE_W-1:0] = mode;
      default: rd = 32'h0000_0000;
    endcase
  end

  // apb answer: ready in the access cycle, data captured at setup
  always_comb begin
    next_pready = setup;
    next_prdata = (setup && !pwrite && hit) ? rd : 32'h0000_0000;
    next_pslverr = setup && !hit;
  end

  // bus registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // motor control registers and outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt <= REG_RST; // R20
      phs_pre <= REG_RST;
      phs_act <= REG_RST;
      cfr <= REG_RST;
      mode <= MODE_RST;
      dir <= 1'b0;
      a_d <= 1'b0;
      pwm_d <= 1'b0;
      zero_event <= 1'b0;
      comm_event <= 1'b0;
      channel_on_off <= 6'h00;
      channel_bits_valid <= 1'b1;
      input_select <= 2'h0;
      encoder_mode <= 1'b0;
      encoder_a <= 1'b0;
      encoder_b <= 1'b0;
      threshold_select <= 3'h0;
      external_threshold_sel <= 1'b0;
      zero_sample_fast <= 1'b0;
      min_off_time_zero <= 1'b0;
      page_select <= 1'b0;
    end else begin
      evt <= next_evt;
      phs_pre <= next_phs_pre;
      phs_act <= next_phs_act;
      cfr <= next_cfr;
      mode <= next_mode;
      dir <= next_dir;
      a_d <= position_input_a;
      pwm_d <= pwm_on;
      zero_event <= next_zero;
      comm_event <= next_comm;
      channel_on_off <= next_phs_act[5:0]; // R12 R13
      channel_bits_valid <= !(next_mode[MODE_PCN] || next_mode[MODE_DTE]); // R13
      input_select <= next_phs_act[7:6]; // R10
      encoder_mode <= next_phs_act[7:6] == IS_ENCODER; // R11
      // encoder taps bypass the analog mux
      encoder_a <= (next_phs_act[7:6] == IS_ENCODER) && position_input_a; // R11
      encoder_b <= (next_phs_act[7:6] == IS_ENCODER) && position_input_b; // R11
      threshold_select <= next_evt[2:0]; // R9
      external_threshold_sel <= next_evt[2:0] == VR_EXTERNAL; // R9
      zero_sample_fast <= next_evt[EVT_FAST_ZERO_SAMPLING] && !mpc_is_speed(next_mode[MODE_TES +: 2]); // R7
      min_off_time_zero <= next_evt[EVT_FAST_ZERO_SAMPLING]; // R8
      page_select <= next_cfr[CFR_PAGE]; // R16
    end
  end

  // current sense filter and blanking window
  mpc_cur_filter u_filter (
    .pclk(pclk),
    .presetn(presetn),
    .soft_clr(soft_rst),
    .filter_count(cfr[CFR_CFF +: 3]),
    .blank_window(cfr[CFR_CFW +: 3]),
    .pwm_on(pwm_on),
    .over_limit(current_over_limit),
    .current_event(current_event),
    .blanking(current_blanking)
  );

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ovf_flag_set: assert property (motor_timer_ovf && !speed && !soft_rst |=> evt[EVT_FLAG]) // R1
    else $error("overflow did not set flag");
  a_speed_flag_set: assert property (speed_error && speed && !soft_rst |=> evt[EVT_FLAG]) // R2
    else $error("speed error did not set flag");
  a_dir_readonly: assert property (wr_evt && speed && !soft_rst |=> evt[EVT_HZ] == $past(evt[EVT_HZ])) // R4
    else $error("direction bit written in speed mode");
  a_sim_zero_out: assert property (evt[EVT_SZ] && sim_zero_req && !soft_rst |=> zero_event) // R5
    else $error("simulated zero lost");
  a_sim_comm_apply: assert property (mode[MODE_SWA] && evt[EVT_SC] && sim_comm_req && !wr_phs && !soft_rst
      |=> comm_event && channel_on_off == $past(phs_pre[5:0])) // R6
    else $error("simulated commutation not applied");
  a_preload_hold: assert property (!comm_src && !wr_phs && !soft_rst |=> $stable(phs_act)) // R14
    else $error("active phase changed without commutation");
  a_direct_access: assert property (dac && wr_phs && !soft_rst
      |=> comm_event && channel_on_off == $past(pwdata[5:0])) // R21
    else $error("direct access write not immediate");
  // the select output is registered on the same edge as the field, so they always agree
  a_ext_threshold: assert property (external_threshold_sel == (evt[2:0] == VR_EXTERNAL)) // R9
    else $error("external threshold not selected");
  a_soft_reset: assert property (soft_rst |=> evt == REG_RST && phs_act == REG_RST && cfr == REG_RST) // R17
    else $error("soft reset left a register set");
  a_apb_ready: assert property (setup |=> pready ##1 !pready) // R15
    else $error("apb answer timing wrong");

  c_direct_comm: cover property (dac && wr_phs ##1 comm_event);
  c_zero_hw: cover property (evt[EVT_HZ] && zero_event);
  c_current_evt: cover property (current_event);
  c_soft_reset: cover property (soft_rst);
endmodule : mpc_phase_regs

// File: test/mpc_motor_model.sv
`timescale 1ns/10ps
module mpc_motor_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // scenario control
  input wire logic spin,
  input wire logic dir,
  input wire logic pwm_req,
  input wire logic over_req,
  // rotor position and current sense
  output logic pos_a,
  output logic pos_b,
  output logic pos_c,
  output logic pwm_on,
  output logic over_limit
);
  logic [2:0] div;
  logic [1:0] step;
  logic [2:0] next_div;
  logic [1:0] next_step;
  // one quadrature step per eight cycles, slow enough for every edge to be seen
  always_comb begin
    next_div = div + 3'h1;
    next_step = step;
    if (spin && div == 3'h7) begin
      next_step = dir ? step + 2'h1 : step - 2'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 3'h0;
      step <= 2'h0;
      pwm_on <= 1'b0;
      over_limit <= 1'b0;
    end else begin
      div <= next_div;
      step <= next_step;
      pwm_on <= pwm_req;
      over_limit <= over_req;
    end
  end
  // gray order: a leads b while dir is high
  assign pos_a = ^step;
  assign pos_b = step[1];
  assign pos_c = step[0];
endmodule : mpc_motor_model

// File: test/mpc_phase_regs_test.sv
`timescale 1ns/10ps
module mpc_phase_regs_test;
  import mpc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, berr, fsc;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d, v;
  logic [3:0] pstrb;
  logic [5:0] ev_in, ch;
  logic [2:0] evo;
  logic spin, dir, pwm_req, over_req, pa, pb, pc, pwm_on, over_limit, found;
  logic zero_event, comm_event, current_event, current_blanking, channel_bits_valid, encoder_mode;
  logic external_threshold_sel, zero_sample_fast, min_off_time_zero, encoder_a, encoder_b, page_select;
  logic [5:0] channel_on_off;
  logic [1:0] input_select;
  logic [2:0] threshold_select;
  integer seed, fail_count, check_count, n;
  mpc_motor_model mpc_motor_model_inst (.pclk(pclk), .presetn(presetn), .spin(spin), .dir(dir),
    .pwm_req(pwm_req), .over_req(over_req), .pos_a(pa), .pos_b(pb), .pos_c(pc), .pwm_on(pwm_on),
    .over_limit(over_limit));
  mpc_phase_regs mpc_phase_regs_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .motor_timer_ovf(ev_in[5]), .speed_error(ev_in[4]), .position_input_a(pa),
    .position_input_b(pb), .position_input_c(pc), .hw_zero_event(ev_in[3]), .sim_zero_req(ev_in[2]),
    .hw_comm_event(ev_in[1]), .sim_comm_req(ev_in[0]), .filter_sample_clock(fsc), .pwm_on(pwm_on),
    .current_over_limit(over_limit), .zero_event(zero_event), .comm_event(comm_event),
    .current_event(current_event), .current_blanking(current_blanking), .channel_on_off(channel_on_off),
    .channel_bits_valid(channel_bits_valid), .input_select(input_select), .encoder_mode(encoder_mode),
    .encoder_a(encoder_a), .encoder_b(encoder_b), .threshold_select(threshold_select),
    .external_threshold_sel(external_threshold_sel), .zero_sample_fast(zero_sample_fast),
    .min_off_time_zero(min_off_time_zero), .page_select(page_select));
  assign evo = {current_event, comm_event, zero_event};
  // free-running clock, 8 ns period
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      if (i == 19) begin
        fail_count++;
        give_verdict();
      end
    end
    rd = prdata;
    berr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] x;
    apb(1'b1, a, wd, x);
  endtask : wr
  task automatic pulse(input int k);
    @(posedge pclk);
    ev_in <= 6'h01 << k;
    @(posedge pclk);
    ev_in <= 6'h00;
  endtask : pulse
  // bounded look for a one-cycle event pulse; the pulse may already stand after the causing edge
  task automatic wait_ev(input int k, output logic f);
    f = 1'b0;
    for (int i = 0; i < 4 && !f; i++) begin
      #1;
      if (evo[k] === 1'b1) f = 1'b1;
      else @(posedge pclk);
    end
  endtask : wait_ev
  initial begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    give_verdict();
  end
  initial begin
    {psel, penable, pwrite, fsc, spin, dir, pwm_req, over_req} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    ev_in = 6'h00;
    seed = 41251;
    fail_count = 0;
    check_count = 0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk(channel_bits_valid, 1);
    for (int a = 0; a < 16; a += 4) begin
      apb(1'b0, a[11:0], 0, d);
      chk(d, 0);
    end
    apb(1'b0, 12'h010, 0, d);
    chk(berr, 1);
    pulse(5);
    apb(1'b0, OFS_EVT, 0, d);
    chk(d[7], 1);
    wr(OFS_EVT, 32'h40);
    apb(1'b0, OFS_EVT, 0, d);
    chk(d, 32'h40);
    // hardware zero at a fast sample point
    wr(OFS_EVT, 32'h48);
    @(posedge pclk);
    fsc <= 1'b1;
    ev_in <= 6'h08;
    @(posedge pclk);
    fsc <= 1'b0;
    ev_in <= 6'h00;
    wait_ev(0, found);
    chk(found, 1);
    for (int c = 0; c < 8; c++) begin
      wr(OFS_EVT, c | (c[0] << 3));
      chk(threshold_select, c);
      chk(external_threshold_sel, c == 7);
      chk({min_off_time_zero, zero_sample_fast}, {2{c[0]}});
    end
    wr(OFS_EVT, 32'h20);
    pulse(2);
    wait_ev(0, found);
    chk(found, 1);
    // preloaded phase values wait for the next commutation
    repeat (4) begin
      v = $random(seed) & 32'hff;
      ch = channel_on_off;
      wr(OFS_PHS, v);
      chk(channel_on_off, ch);
      pulse(1);
      wait_ev(1, found);
      chk({found, input_select, channel_on_off}, {1'b1, v[7:0]});
      chk(encoder_mode, v[7:6] == IS_ENCODER);
      apb(1'b0, OFS_PHS, 0, d);
      chk(d, v);
    end
    pstrb <= 4'h0;
    wr(OFS_PHS, ~v & 32'hff);
    pstrb <= 4'hf;
    apb(1'b0, OFS_PHS, 0, d);
    chk(d, v);
    wr(OFS_MODE, 32'h08);
    v = $random(seed) & 32'h3f;
    wr(OFS_PHS, v);
    wait_ev(1, found);
    chk({found, channel_on_off}, {1'b1, v[5:0]});
    wr(OFS_MODE, 32'h04);
    wr(OFS_EVT, 32'h10);
    pulse(1);
    wait_ev(1, found);
    chk(found, 0);
    pulse(0);
    wait_ev(1, found);
    chk(found, 1);
    wr(OFS_MODE, 32'h10);
    chk(channel_bits_valid, 0);
    wr(OFS_MODE, 32'h20);
    chk(channel_bits_valid, 0);
    wr(OFS_MODE, 32'h01);
    chk(channel_bits_valid, 1);
    // encoder selection so the digital taps follow the position inputs
    wr(OFS_PHS, 32'hc0);
    pulse(1);
    // speed mode: bit 6 reports quadrature order
    for (int k = 1; k >= 0; k--) begin
      spin <= 1'b1;
      dir <= k[0];
      repeat (64) @(posedge pclk);
      apb(1'b0, OFS_EVT, 0, d);
      chk(d[6], k[0]);
      // taps lag the inputs by one cycle; eight cycles span a step change
      repeat (8) begin
        v[1:0] = {pa, pb};
        @(posedge pclk);
        #1;
        chk({encoder_a, encoder_b}, v[1:0]);
      end
    end
    spin <= 1'b0;
    wr(OFS_EVT, 32'h00);
    pulse(4);
    apb(1'b0, OFS_EVT, 0, d);
    chk(d[7], 1);
    wr(OFS_MODE, 32'h00);
    // filter needs code+1 samples at a quarter of the clock
    for (int c = 0; c < 8; c += 7) begin
      wr(OFS_CFR, c << 3);
      over_req <= 1'b1;
      n = 0;
      while (current_event !== 1'b1 && n < 64) begin
        @(posedge pclk);
        #1;
        n++;
      end
      chk(n >= c * 4 && n <= c * 4 + 9, 1);
      over_req <= 1'b0;
      repeat (8) @(posedge pclk);
    end
    wr(OFS_CFR, 32'h03);
    pwm_req <= 1'b1;
    n = 0;
    repeat (20) begin
      @(posedge pclk);
      #1;
      if (current_blanking === 1'b1) n++;
    end
    chk(n, 6);
    pwm_req <= 1'b0;
    // hardware zero taken only at the pwm turn-on sample point
    wr(OFS_EVT, 32'h40);
    pwm_req <= 1'b1;
    @(posedge pclk);
    ev_in <= 6'h08;
    @(posedge pclk);
    ev_in <= 6'h00;
    wait_ev(0, found);
    chk(found, 1);
    pulse(3);
    wait_ev(0, found);
    chk(found, 0);
    pwm_req <= 1'b0;
    wr(OFS_EVT, 32'h11);
    wr(OFS_CFR, 32'h80);
    chk(page_select, 1);
    apb(1'b0, OFS_EVT, 0, d);
    chk(d, 32'hc0);
    wr(OFS_EVT, 32'h25);
    wr(OFS_CFR, 32'h00);
    apb(1'b0, OFS_EVT, 0, d);
    chk(d, 32'h11);
    wr(OFS_MODE, 32'h0d);
    wr(OFS_CFR, 32'h40);
    for (int a = 0; a < 16; a += 4) begin
      apb(1'b0, a[11:0], 0, d);
      chk(d, 0);
    end
    chk({page_select, input_select, channel_on_off}, 0);
    give_verdict();
  end
endmodule : mpc_phase_regs_test
